// ---- src/awc_consts.svh ----
// constants for the acquisition window and offset correction block
`ifndef AWC_CONSTS_SVH
`define AWC_CONSTS_SVH

// channel count and field widths
`define AWC_CHAN_N 16
`define AWC_CHAN_W 4
`define AWC_WIN_W 10
`define AWC_OFS_W 10
`define AWC_RAW_W 12
`define AWC_EXT_W 14

// window timing, slow grade table
`define AWC_T_STEP_100_PS 10000
`define AWC_T_MIN_100_NS 80
`define AWC_T_MAX_100_NS 5100

// window timing, fast grade table
`define AWC_T_STEP_200_PS 5000
`define AWC_T_MIN_200_NS 75
`define AWC_T_MAX_200_NS 2600

// unit conversion and step counts derived from times
`define AWC_PS_PER_NS 1000
`define AWC_MIN_STEPS(t_ns, s_ps) \
    (((t_ns) * `AWC_PS_PER_NS + (s_ps) - 1) / (s_ps))
`define AWC_MAX_STEPS(t_ns, s_ps) (((t_ns) * `AWC_PS_PER_NS) / (s_ps))

// result limits and reset values
`define AWC_RAW_MAX 12'hfff
`define AWC_RAW_MIN 12'h000
`define AWC_WIN_RST 10'h000
`define AWC_OFS_RST 10'h000
`define AWC_WIN_ONE 10'h001

`endif

// ---- src/awc_pkg.sv ----
// types shared by the acquisition window and offset correction block
`default_nettype none
`include "awc_consts.svh"

package awc_pkg;
    typedef enum logic [1:0] {st_idle, st_load, st_acq, st_conv} awc_state_t;
    typedef logic [`AWC_CHAN_W-1:0] awc_chan_t;
    typedef logic [`AWC_WIN_W-1:0] awc_win_t;
    typedef logic signed [`AWC_OFS_W-1:0] awc_ofs_t;
    typedef logic [`AWC_RAW_W-1:0] awc_raw_t;
    typedef logic signed [`AWC_EXT_W-1:0] awc_ext_t;
    typedef logic [`AWC_WIN_W+`AWC_OFS_W-1:0] awc_word_t;
endpackage

`default_nettype wire

// ---- src/awc_cfg_mem.sv ----
// per-channel window and offset store with registered read
`timescale 1ns/1ns
`default_nettype none
`include "awc_consts.svh"

module awc_cfg_mem (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // write port
    input wire logic wr_en,
    input wire awc_pkg::awc_chan_t wr_addr,
    input wire awc_pkg::awc_word_t wr_data,
    // read port
    input wire awc_pkg::awc_chan_t rd_addr,
    output var awc_pkg::awc_word_t rd_data
);
    import awc_pkg::*;

    awc_word_t mem [`AWC_CHAN_N];
    awc_word_t next_rd_data;

    // one independent entry per channel
    genvar i;
    generate
        for (i = 0; i < `AWC_CHAN_N; i++) begin : g_entry
            awc_word_t next_entry;
            always_comb begin
                next_entry = mem[i];
                if (wr_en && (wr_addr == awc_chan_t'(i))) begin
                    next_entry = wr_data;
                end
            end
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    mem[i] <= {`AWC_WIN_RST, `AWC_OFS_RST};
                end else begin
                    mem[i] <= next_entry;
                end
            end
        end
    endgenerate

    // read data leaves from a register
    always_comb begin
        next_rd_data = mem[rd_addr];
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_data <= {`AWC_WIN_RST, `AWC_OFS_RST};
        end else begin
            rd_data <= next_rd_data;
        end
    end
endmodule

`default_nettype wire

// ---- src/awc_acq_offset.sv ----
// acquisition window timer and saturating offset correction
// Summary of operation
// - every channel keeps its own window length, chosen per conversion
// - slow grade: window 8 to 510 steps of one clock each
// - fast grade: window 15 to 520 steps of one clock each
// - signed ten-bit offset is subtracted from each result in hardware
// - corrected result clamps to zero or full scale, never wraps
// - correction adds one cycle of latency, never stalls conversions
`timescale 1ns/1ns
`default_nettype none
`include "awc_consts.svh"

module awc_acq_offset (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // per-channel configuration write
    input wire logic cfg_wr,
    input wire awc_pkg::awc_chan_t cfg_chan,
    input wire awc_pkg::awc_win_t acq_window_length,
    input wire awc_pkg::awc_ofs_t cfg_offset,
    // window table select, high for the fast grade
    input wire logic rate_grade,
    // conversion request
    input wire logic soc_req,
    input wire awc_pkg::awc_chan_t soc_chan,
    output logic busy,
    // converter core
    output logic sh_sample,
    output logic conv_start,
    output awc_pkg::awc_chan_t conv_chan,
    input wire logic conv_done,
    input wire awc_pkg::awc_raw_t conv_data,
    // corrected result
    output logic result_valid,
    output awc_pkg::awc_chan_t result_chan,
    output awc_pkg::awc_raw_t result_data,
    output logic result_sat
);
    import awc_pkg::*;

    localparam awc_win_t win_min_100 =
        awc_win_t'(`AWC_MIN_STEPS(`AWC_T_MIN_100_NS, `AWC_T_STEP_100_PS));
    localparam awc_win_t win_max_100 =
        awc_win_t'(`AWC_MAX_STEPS(`AWC_T_MAX_100_NS, `AWC_T_STEP_100_PS));
    localparam awc_win_t win_min_200 =
        awc_win_t'(`AWC_MIN_STEPS(`AWC_T_MIN_200_NS, `AWC_T_STEP_200_PS));
    localparam awc_win_t win_max_200 =
        awc_win_t'(`AWC_MAX_STEPS(`AWC_T_MAX_200_NS, `AWC_T_STEP_200_PS));

    awc_state_t state, next_state;
    awc_win_t count, next_count;
    awc_win_t win_eff, next_win_eff;
    awc_ofs_t offset, next_offset;
    awc_chan_t next_conv_chan;
    logic next_busy, next_sh_sample, next_conv_start;
    logic next_result_valid, next_result_sat;
    awc_chan_t next_result_chan;
    awc_raw_t next_result_data;
    awc_word_t rd_word;
    awc_win_t rd_win, rd_clamped;
    awc_ofs_t rd_ofs;
    awc_ext_t diff;
    logic take_done;

    // clamps a stored window to the limits of the selected grade
    function automatic awc_win_t clamp_window(input awc_win_t w,
                                              input logic grade);
        awc_win_t lo;
        awc_win_t hi;
        lo = grade ? win_min_200 : win_min_100;
        hi = grade ? win_max_200 : win_max_100;
        if (w < lo) begin
            return lo;
        end else if (w > hi) begin
            return hi;
        end
        return w;
    endfunction

    // channel settings store
    awc_cfg_mem u_cfg_mem (
        .clk_sys(clk_sys),
        .reset(reset),
        .wr_en(cfg_wr),
        .wr_addr(cfg_chan),
        .wr_data({acq_window_length, cfg_offset}),
        .rd_addr(next_conv_chan),
        .rd_data(rd_word)
    );

    // split the stored word and bound the window
    assign rd_win = rd_word[`AWC_WIN_W+`AWC_OFS_W-1:`AWC_OFS_W];
    assign rd_ofs = awc_ofs_t'(rd_word[`AWC_OFS_W-1:0]);
    assign rd_clamped = clamp_window(rd_win, rate_grade);

    // sequencer: request, load, acquire, convert
    always_comb begin
        next_state = state;
        next_count = count;
        next_win_eff = win_eff;
        next_offset = offset;
        next_conv_chan = conv_chan;
        next_sh_sample = 1'b0;
        next_conv_start = 1'b0;
        case (state)
            st_idle: begin
                if (soc_req) begin
                    next_conv_chan = soc_chan;
                    next_state = st_load;
                end
            end
            st_load: begin
                next_win_eff = rd_clamped;
                next_count = rd_clamped - `AWC_WIN_ONE;
                next_offset = rd_ofs;
                next_sh_sample = 1'b1;
                next_state = st_acq;
            end
            st_acq: begin
                if (count == `AWC_WIN_RST) begin
                    next_conv_start = 1'b1;
                    next_state = st_conv;
                end else begin
                    next_count = count - `AWC_WIN_ONE;
                    next_sh_sample = 1'b1;
                end
            end
            st_conv: begin
                if (conv_done) begin
                    next_state = st_idle;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
        next_busy = (next_state != st_idle);
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= st_idle;
            count <= `AWC_WIN_RST;
            win_eff <= `AWC_WIN_RST;
            offset <= `AWC_OFS_RST;
            conv_chan <= '0;
            busy <= 1'b0;
            sh_sample <= 1'b0;
            conv_start <= 1'b0;
        end else begin
            state <= next_state;
            count <= next_count;
            win_eff <= next_win_eff;
            offset <= next_offset;
            conv_chan <= next_conv_chan;
            busy <= next_busy;
            sh_sample <= next_sh_sample;
            conv_start <= next_conv_start;
        end
    end

    // correction stage, one register after the converter answer
    assign take_done = (state == st_conv) && conv_done;
    assign diff = awc_ext_t'({2'h0, conv_data}) - awc_ext_t'(offset);

    always_comb begin
        next_result_valid = take_done;
        next_result_chan = result_chan;
        next_result_data = result_data;
        next_result_sat = result_sat;
        if (take_done) begin
            next_result_chan = conv_chan;
            next_result_sat = 1'b0;
            if (diff < awc_ext_t'(`AWC_RAW_MIN)) begin
                next_result_data = `AWC_RAW_MIN;
                next_result_sat = 1'b1;
            end else if (diff > awc_ext_t'({2'h0, `AWC_RAW_MAX})) begin
                next_result_data = `AWC_RAW_MAX;
                next_result_sat = 1'b1;
            end else begin
                next_result_data = awc_raw_t'(diff);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            result_valid <= 1'b0;
            result_chan <= '0;
            result_data <= `AWC_RAW_MIN;
            result_sat <= 1'b0;
        end else begin
            result_valid <= next_result_valid;
            result_chan <= next_result_chan;
            result_data <= next_result_data;
            result_sat <= next_result_sat;
        end
    end

    // helper: length of the current sample pulse
    awc_win_t sh_len, next_sh_len;
    always_comb begin
        next_sh_len = `AWC_WIN_RST;
        if (sh_sample) begin
            next_sh_len = sh_len + `AWC_WIN_ONE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sh_len <= `AWC_WIN_RST;
        end else begin
            sh_len <= next_sh_len;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // pulse length equals the window picked for that channel
    property p_win_len;
        $fell(sh_sample) |-> (sh_len == win_eff) && conv_start;
    endproperty
    a_win_len: assert property (p_win_len)
        else $error("sample pulse length differs from window");

    property p_win_chan;
        $rose(sh_sample) |-> win_eff == $past(rd_clamped);
    endproperty
    a_win_chan: assert property (p_win_chan)
        else $error("window not taken from requested channel");

    property p_win_slow;
        $rose(sh_sample) && !rate_grade |->
            (win_eff >= awc_win_t'(8)) && (win_eff <= awc_win_t'(510));
    endproperty
    a_win_slow: assert property (p_win_slow)
        else $error("slow grade window out of range");

    property p_win_fast;
        $rose(sh_sample) && rate_grade |->
            (win_eff >= awc_win_t'(15)) && (win_eff <= awc_win_t'(520));
    endproperty
    a_win_fast: assert property (p_win_fast)
        else $error("fast grade window out of range");

    property p_offset;
        take_done && !next_result_sat |=>
            result_data == awc_raw_t'($past(conv_data) -
                                      awc_raw_t'($past(offset)));
    endproperty
    a_offset: assert property (p_offset)
        else $error("offset not subtracted");

    property p_sat_hi;
        take_done && (diff > awc_ext_t'(4095)) |=>
            result_sat && (result_data == `AWC_RAW_MAX);
    endproperty
    a_sat_hi: assert property (p_sat_hi)
        else $error("overflow did not clamp to full scale");

    property p_sat_lo;
        take_done && (diff < awc_ext_t'(0)) |=>
            result_sat && (result_data == `AWC_RAW_MIN);
    endproperty
    a_sat_lo: assert property (p_sat_lo)
        else $error("underflow did not clamp to zero");

    property p_no_stall;
        take_done |=> result_valid && !busy
            && (result_chan == $past(conv_chan));
    endproperty
    a_no_stall: assert property (p_no_stall)
        else $error("correction delayed the result");

    c_sat_hi: cover property (result_valid && result_sat
                              && result_data == `AWC_RAW_MAX);
    c_sat_lo: cover property (result_valid && result_sat
                              && result_data == `AWC_RAW_MIN);
    c_fast_max: cover property ($fell(sh_sample) && rate_grade
                                && sh_len == win_max_200);
    c_back_to_back: cover property (result_valid ##1 busy);
endmodule

`default_nettype wire

// ---- testbench/awc_core_model.sv ----
// converter core stand-in answering each start after a set latency
`timescale 1ns/1ns
`default_nettype none

module awc_core_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // latency and sample chosen by the bench
    input wire logic [7:0] lat,
    input wire awc_pkg::awc_raw_t sample_val,
    // converter handshake
    input wire logic conv_start,
    output logic conv_done,
    output awc_pkg::awc_raw_t conv_data
);
    import awc_pkg::*;

    // one answer per start; data line shows the inverse after each strobe, 12'h5a5 before the first
    initial begin
        conv_done = 1'b0;
        conv_data = 12'h5a5;
        forever begin
            @(posedge clk_sys);
            if (conv_start === 1'b1 && reset === 1'b0) begin
                repeat (lat - 8'h01) @(posedge clk_sys);
                conv_done <= 1'b1;
                conv_data <= sample_val;
                @(posedge clk_sys);
                conv_done <= 1'b0;
                conv_data <= ~sample_val;
            end
        end
    end
endmodule

`default_nettype wire

// ---- testbench/awc_acq_offset_tb.sv ----
// self-checking bench for the window timer and offset correction
`timescale 1ns/1ns
`default_nettype none

module awc_acq_offset_tb;
    import awc_pkg::*;

    logic clk_sys, reset, cfg_wr, rate_grade, soc_req;
    awc_chan_t cfg_chan, soc_chan, conv_chan, result_chan;
    awc_win_t acq_window_length;
    awc_ofs_t cfg_offset;
    logic busy, sh_sample, conv_start, conv_done, result_valid, result_sat;
    awc_raw_t conv_data, result_data, model_val;
    logic [7:0] lat;
    int n_errors = 0;
    int checks = 0;

    awc_acq_offset awc_acq_offset_i (.clk_sys(clk_sys), .reset(reset),
        .cfg_wr(cfg_wr), .cfg_chan(cfg_chan),
        .acq_window_length(acq_window_length), .cfg_offset(cfg_offset),
        .rate_grade(rate_grade), .soc_req(soc_req), .soc_chan(soc_chan),
        .busy(busy), .sh_sample(sh_sample), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_done(conv_done),
        .conv_data(conv_data), .result_valid(result_valid),
        .result_chan(result_chan), .result_data(result_data),
        .result_sat(result_sat));

    awc_core_model awc_core_model_i (.clk_sys(clk_sys), .reset(reset),
        .lat(lat), .sample_val(model_val), .conv_start(conv_start),
        .conv_done(conv_done), .conv_data(conv_data));

    // 250 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
            n_errors++;
        end
    endtask

    // a wait that ran out of its bound ends the run
    task automatic guard(input int c, input int lim);
        if (c >= lim) begin
            n_errors++;
            tally_and_finish();
        end
    endtask

    task automatic cfg(input awc_chan_t ch, input awc_win_t w,
            input awc_ofs_t o);
        @(posedge clk_sys);
        cfg_wr <= 1'b1;
        cfg_chan <= ch;
        acq_window_length <= w;
        cfg_offset <= o;
        @(posedge clk_sys);
        cfg_wr <= 1'b0;
    endtask

    // one conversion, timed and judged; poke retries soc while busy
    task automatic run_conv(input awc_chan_t ch, input awc_raw_t raw,
            input logic [7:0] l, input logic poke, input int exp_w,
            input awc_raw_t exp_d, input logic exp_s);
        int n;
        int w;
        n = 0;
        w = 0;
        @(posedge clk_sys);
        lat <= l;
        model_val <= raw;
        soc_req <= 1'b1;
        soc_chan <= ch;
        @(posedge clk_sys);
        soc_req <= 1'b0;
        #1;
        while (sh_sample !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        guard(n, 50);
        chk("window start", 16'h0001, 16'(n));
        chk("conv_chan", 16'(ch), 16'(conv_chan));
        if (poke) begin
            @(posedge clk_sys);
            soc_req <= 1'b1;
            soc_chan <= awc_chan_t'(ch + 4'h1);
            @(posedge clk_sys);
            soc_req <= 1'b0;
            #1;
            w = 2;
        end
        while (sh_sample === 1'b1 && w < 600) begin
            @(posedge clk_sys);
            #1;
            w++;
        end
        guard(w, 600);
        chk("window length", 16'(exp_w), 16'(w));
        chk("conv_start", 16'h0001, 16'(conv_start));
        n = 0;
        while (result_valid !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        guard(n, 50);
        chk("result latency", 16'(l) + 16'h0001, 16'(n));
        chk("result_data", 16'(exp_d), 16'(result_data));
        chk("result_sat", 16'(exp_s), 16'(result_sat));
        chk("result_chan", 16'(ch), 16'(result_chan));
        chk("busy at result", 16'h0000, 16'(busy));
        if (poke) begin
            repeat (4) @(posedge clk_sys);
            #1;
            chk("no restart", 16'h0000, 16'(sh_sample));
        end
    endtask

    task automatic test_channels();
        cfg(4'h1, 10'h014, 10'h000);
        cfg(4'h2, 10'h028, 10'h000);
        run_conv(4'h1, 12'h123, 8'h01, 1'b0, 20, 12'h123, 1'b0);
        run_conv(4'h2, 12'h321, 8'h02, 1'b0, 40, 12'h321, 1'b0);
        $display("test channels done");
    endtask

    task automatic test_bounds();
        @(posedge clk_sys);
        rate_grade <= 1'b0;
        cfg(4'h4, 10'h003, 10'h000);
        cfg(4'h5, 10'h3e8, 10'h000);
        run_conv(4'h4, 12'h010, 8'h01, 1'b0, 8, 12'h010, 1'b0);
        run_conv(4'h5, 12'h020, 8'h01, 1'b0, 510, 12'h020, 1'b0);
        run_conv(4'h6, 12'h030, 8'h01, 1'b0, 8, 12'h030, 1'b0);
        @(posedge clk_sys);
        rate_grade <= 1'b1;
        cfg(4'h7, 10'h010, 10'h000);
        run_conv(4'h4, 12'h040, 8'h01, 1'b0, 15, 12'h040, 1'b0);
        run_conv(4'h5, 12'h050, 8'h01, 1'b0, 520, 12'h050, 1'b0);
        run_conv(4'h7, 12'h060, 8'h01, 1'b0, 16, 12'h060, 1'b0);
        $display("test bounds done");
    endtask

    task automatic test_offset();
        @(posedge clk_sys);
        rate_grade <= 1'b0;
        cfg(4'h8, 10'h00c, 10'h01e);
        run_conv(4'h8, 12'h064, 8'h03, 1'b0, 12, 12'h046, 1'b0);
        cfg(4'h8, 10'h00c, 10'h3ec);
        run_conv(4'h8, 12'h064, 8'h03, 1'b0, 12, 12'h078, 1'b0);
        cfg(4'h9, 10'h00c, 10'h1ff);
        run_conv(4'h9, 12'h1ff, 8'h01, 1'b0, 12, 12'h000, 1'b0);
        cfg(4'h9, 10'h00c, 10'h200);
        run_conv(4'h9, 12'hdff, 8'h01, 1'b0, 12, 12'hfff, 1'b0);
        cfg(4'ha, 10'h00c, 10'h032);
        run_conv(4'ha, 12'h00a, 8'h01, 1'b0, 12, 12'h000, 1'b1);
        cfg(4'hb, 10'h00c, 10'h39c);
        run_conv(4'hb, 12'hffa, 8'h01, 1'b0, 12, 12'hfff, 1'b1);
        $display("test offset done");
    endtask

    task automatic test_rate();
        run_conv(4'hc, 12'h7ff, 8'h01, 1'b1, 8, 12'h7ff, 1'b0);
        run_conv(4'hc, 12'h800, 8'h06, 1'b0, 8, 12'h800, 1'b0);
        $display("test rate done");
    endtask

    // reset, then each scenario in turn
    initial begin
        reset = 1'b1;
        cfg_wr = 1'b0;
        cfg_chan = 4'h0;
        acq_window_length = 10'h000;
        cfg_offset = 10'h000;
        rate_grade = 1'b0;
        soc_req = 1'b0;
        soc_chan = 4'h0;
        lat = 8'h01;
        model_val = 12'h000;
        repeat (20) @(posedge clk_sys);
        reset <= 1'b0;
        #1;
        chk("busy after reset", 16'h0000, 16'(busy));
        test_channels();
        test_bounds();
        test_offset();
        test_rate();
        tally_and_finish();
    end
endmodule

`default_nettype wire
